// ===== logic/cmjd_decode.sv
/*
  Executes long call, long jump, byte and bit copies, pointer load,
  code byte reads and external data moves of a small 8-bit core.
  Assumes the fetch unit holds one instruction stable while
  instr_valid is high and waits for done_q before the next one.
*/
// What this block does
// - Call pushes PC+3, low byte first
// - Long branch loads PC from bytes two, three
// - Branch targets reach all 16-bit space
// - Byte copy leaves source and flags alone
// - Fifteen byte copy mode pairs supported
// - Bit copy between carry and addressable bit
// - Pointer load: byte two high, three low
// - Code read at accumulator plus base
// - PC base advanced before the addition
// - Address sum carries through all sixteen bits
// - External move: one byte, two machine cycles
// - Short form drives indirect register address
// - Long form: high port, low multiplexed
// - High port keeps address, old data lost
// - Short form upper bits from port latch
module cmjd_decode (
  input logic mclk, // Core clock
  input logic srst, // Synchronous reset
  input logic instr_valid, // Instruction presented
  input cmjd_pkg::cmjd_instr_t instr, // Opcode and operand bytes
  input logic [1:0] bank, // Current register bank
  input logic code_valid, // Code byte returned
  input logic [7:0] code_data, // Code byte value
  input logic p2_we, // Core writes high port latch
  input logic [7:0] p2_wd, // Value for high port latch
  input logic [7:0] ad_in, // Address/data pins, sampled
  input logic [7:0] dbg_addr, // Internal RAM peek address
  output logic done_q, // Instruction finished pulse
  output logic bad_q, // Opcode not handled pulse
  output logic [15:0] pc_q, // Program counter
  output logic [7:0] acc_q, // Accumulator
  output logic [7:0] sp_q, // Stack pointer
  output logic [15:0] data_pointer16_q, // Data pointer
  output logic carry_q, // Carry flag
  output logic code_req_q, // Code read request pulse
  output logic [15:0] code_addr_q, // Code read address
  output cmjd_pkg::cmjd_xbus_t xbus_q, // Address/data port
  output logic [7:0] p2_q, // High address port
  output logic [7:0] dbg_q // Internal RAM peek data
);

  cmjd_pkg::cmjd_state_t st_q; // Sequencer state
  logic [7:0] iram [256]; // Internal RAM, bank registers included
  logic [4:0] xcnt_q; // Clock count inside an external move
  logic x_wr_q; // External move writes
  logic [7:0] ad_s1_q; // Pin synchroniser, first stage
  logic [7:0] ad_s2_q; // Pin synchroniser, second stage
  logic go; // Instruction accepted this cycle
  logic [7:0] rn_a; // Bank register address
  logic [7:0] ri_a; // Contents of the indirect register
  logic [7:0] bit_byte; // Byte holding the addressed bit
  logic bit_val; // Addressed bit value
  logic [15:0] ret_addr; // Return address of a call
  logic [15:0] step; // PC advance
  logic jmp; // Load PC from operand bytes
  logic call; // Push return address
  logic we; // Internal RAM write
  logic [7:0] wa; // Internal RAM write address
  logic [7:0] wd; // Internal RAM write data
  logic acc_we; // Accumulator load
  logic [7:0] acc_wd; // Accumulator data
  logic c_we; // Carry load
  logic dp_we; // Pointer load
  logic code_go; // Start a code read
  logic [15:0] code_a; // Code read address
  logic x_go; // Start an external move
  logic x_wr; // External move direction is write
  logic x_dp; // External move uses the pointer
  logic bad; // Unhandled opcode
  logic [7:0] bit_wd; // Byte with carry merged in

  assign go = instr_valid && (st_q == cmjd_pkg::ST_IDLE);
  assign rn_a = {cmjd_pkg::BANK_HI, bank, instr.opc[2:0]};
  assign ri_a = iram[{cmjd_pkg::BANK_HI, bank, cmjd_pkg::RI_MID,
                      instr.opc[0]}];
  // Low half of the bit space maps onto the bit RAM bytes
  assign bit_byte = instr.b2[7] ? {instr.b2[7:3], 3'h0}
                    : cmjd_pkg::BIT_RAM + {4'h0, instr.b2[6:3]};
  assign bit_val = iram[bit_byte][instr.b2[2:0]];
  assign ret_addr = pc_q + cmjd_pkg::PC3;

  // Decode: every form resolves in one cycle except code and external
  always_comb begin
    step = cmjd_pkg::PC1;
    jmp = 1'b0;
    call = 1'b0;
    we = 1'b0;
    wa = instr.b2;
    wd = acc_q;
    acc_we = 1'b0;
    acc_wd = instr.b2;
    c_we = 1'b0;
    dp_we = 1'b0;
    code_go = 1'b0;
    code_a = data_pointer16_q + {8'h00, acc_q};
    x_go = 1'b0;
    x_wr = 1'b0;
    x_dp = 1'b0;
    bad = 1'b0;
    bit_wd = iram[bit_byte];
    bit_wd[instr.b2[2:0]] = carry_q;
    unique casez (instr.opc)
      cmjd_pkg::OP_LONG_SUBROUTINE_CALL: begin
        call = 1'b1;
        jmp = 1'b1;
      end
      cmjd_pkg::OP_LONG_BRANCH: jmp = 1'b1;
      cmjd_pkg::OP_A_RN: begin
        acc_we = 1'b1;
        acc_wd = iram[rn_a];
      end
      cmjd_pkg::OP_A_DIR: begin
        step = cmjd_pkg::PC2;
        acc_we = 1'b1;
        acc_wd = iram[instr.b2];
      end
      cmjd_pkg::OP_A_RI: begin
        acc_we = 1'b1;
        acc_wd = iram[ri_a];
      end
      cmjd_pkg::OP_A_IMM: begin
        step = cmjd_pkg::PC2;
        acc_we = 1'b1;
      end
      cmjd_pkg::OP_RN_A: begin
        we = 1'b1;
        wa = rn_a;
      end
      cmjd_pkg::OP_RN_DIR: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wa = rn_a;
        wd = iram[instr.b2];
      end
      cmjd_pkg::OP_RN_IMM: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wa = rn_a;
        wd = instr.b2;
      end
      cmjd_pkg::OP_DIR_A: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
      end
      cmjd_pkg::OP_DIR_RN: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wd = iram[rn_a];
      end
      cmjd_pkg::OP_DIR_DIR: begin
        // Source comes first, destination second
        step = cmjd_pkg::PC3;
        we = 1'b1;
        wa = instr.b3;
        wd = iram[instr.b2];
      end
      cmjd_pkg::OP_DIR_RI: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wd = iram[ri_a];
      end
      cmjd_pkg::OP_DIR_IMM: begin
        step = cmjd_pkg::PC3;
        we = 1'b1;
        wd = instr.b3;
      end
      cmjd_pkg::OP_RI_A: begin
        we = 1'b1;
        wa = ri_a;
      end
      cmjd_pkg::OP_RI_DIR: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wa = ri_a;
        wd = iram[instr.b2];
      end
      cmjd_pkg::OP_RI_IMM: begin
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wa = ri_a;
        wd = instr.b2;
      end
      cmjd_pkg::OP_C_BIT: begin
        step = cmjd_pkg::PC2;
        c_we = 1'b1;
      end
      cmjd_pkg::OP_BIT_C: begin
        // Read-modify-write touches only the addressed bit
        step = cmjd_pkg::PC2;
        we = 1'b1;
        wa = bit_byte;
        wd = bit_wd;
      end
      cmjd_pkg::OP_DATA_POINTER16: begin
        step = cmjd_pkg::PC3;
        dp_we = 1'b1;
      end
      cmjd_pkg::OP_CODE_DP: code_go = 1'b1;
      cmjd_pkg::OP_CODE_PC: begin
        code_go = 1'b1;
        code_a = pc_q + cmjd_pkg::PC1 + {8'h00, acc_q};
      end
      cmjd_pkg::OP_XRD_RI: x_go = 1'b1;
      cmjd_pkg::OP_XRD_DP: begin
        x_go = 1'b1;
        x_dp = 1'b1;
      end
      cmjd_pkg::OP_XWR_RI: begin
        x_go = 1'b1;
        x_wr = 1'b1;
      end
      cmjd_pkg::OP_XWR_DP: begin
        x_go = 1'b1;
        x_wr = 1'b1;
        x_dp = 1'b1;
      end
      default: begin
        // Left for other decoders: PC holds, bad_q tells the core
        step = cmjd_pkg::PC0;
        bad = 1'b1;
      end
    endcase
  end

  // Internal RAM; a call writes two stack bytes in the same edge
  always_ff @(posedge mclk) begin
    if (go && we) begin
      iram[wa] <= wd;
    end
    if (go && call) begin
      iram[sp_q + cmjd_pkg::SP_INC] <= ret_addr[7:0];
      iram[sp_q + cmjd_pkg::SP_INC + cmjd_pkg::SP_INC]
        <= ret_addr[15:8];
    end
    dbg_q <= iram[dbg_addr];
  end

  // Program counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_q <= cmjd_pkg::PC_RST;
    end else if (go) begin
      pc_q <= jmp ? {instr.b2, instr.b3} : pc_q + step;
    end
  end

  // Stack pointer, pointer and carry
  always_ff @(posedge mclk) begin
    if (srst) begin
      sp_q <= cmjd_pkg::SP_RST;
      data_pointer16_q <= cmjd_pkg::DATA_POINTER16_RST;
      carry_q <= 1'b0;
    end else if (go) begin
      if (call) begin
        sp_q <= sp_q + cmjd_pkg::SP_INC + cmjd_pkg::SP_INC;
      end
      if (dp_we) begin
        data_pointer16_q <= {instr.b2, instr.b3};
      end
      if (c_we) begin
        carry_q <= bit_val;
      end
    end
  end

  // Accumulator: copy, code byte or external read
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_q <= cmjd_pkg::BYTE_RST;
    end else if (go && acc_we) begin
      acc_q <= acc_wd;
    end else if (st_q == cmjd_pkg::ST_CODE && code_valid) begin
      acc_q <= code_data;
    end else if (st_q == cmjd_pkg::ST_XFER && !x_wr_q
                 && xcnt_q == cmjd_pkg::XFER_LAST) begin
      acc_q <= ad_s2_q;
    end
  end

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge mclk) begin
    ad_s1_q <= ad_in;
    ad_s2_q <= ad_s1_q;
  end

  // High port latch; a pointer move overwrites the output data
  always_ff @(posedge mclk) begin
    if (srst) begin
      p2_q <= cmjd_pkg::P2_RST;
    end else if (go && x_go && x_dp) begin
      p2_q <= data_pointer16_q[15:8];
    end else if (p2_we && st_q == cmjd_pkg::ST_IDLE) begin
      p2_q <= p2_wd;
    end
  end

  // Sequencer: one-cycle ops, code reads and external moves
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= cmjd_pkg::ST_IDLE;
      done_q <= 1'b0;
      bad_q <= 1'b0;
      code_req_q <= 1'b0;
      code_addr_q <= cmjd_pkg::PC_RST;
      xcnt_q <= 5'h00;
      x_wr_q <= 1'b0;
      xbus_q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad_oe: 1'b0,
                  ad: cmjd_pkg::BYTE_RST};
    end else begin
      done_q <= 1'b0;
      bad_q <= 1'b0;
      code_req_q <= 1'b0;
      unique case (st_q)
        cmjd_pkg::ST_IDLE: begin
          if (go && code_go) begin
            code_req_q <= 1'b1;
            code_addr_q <= code_a;
            st_q <= cmjd_pkg::ST_CODE;
          end else if (go && x_go) begin
            // Address phase: latch strobe with address on the port
            xcnt_q <= 5'h00;
            x_wr_q <= x_wr;
            xbus_q.ale <= 1'b1;
            xbus_q.ad_oe <= 1'b1;
            xbus_q.ad <= x_dp ? data_pointer16_q[7:0] : ri_a;
            st_q <= cmjd_pkg::ST_XFER;
          end else if (go) begin
            done_q <= 1'b1;
            bad_q <= bad;
          end
        end
        cmjd_pkg::ST_CODE: begin
          if (code_valid) begin
            done_q <= 1'b1;
            st_q <= cmjd_pkg::ST_IDLE;
          end
        end
        cmjd_pkg::ST_XFER: begin
          xcnt_q <= xcnt_q + cmjd_pkg::CNT_ONE;
          if (xcnt_q == cmjd_pkg::ALE_LAST) begin
            // Data phase: release for a read, drive the byte for a write
            xbus_q.ale <= 1'b0;
            xbus_q.ad_oe <= x_wr_q;
            xbus_q.ad <= x_wr_q ? acc_q : cmjd_pkg::BYTE_RST;
            xbus_q.rd_n <= x_wr_q;
            xbus_q.wr_n <= !x_wr_q;
          end
          if (xcnt_q == cmjd_pkg::XFER_LAST) begin
            xbus_q.rd_n <= 1'b1;
            xbus_q.wr_n <= 1'b1;
            xbus_q.ad_oe <= 1'b0;
            done_q <= 1'b1;
            st_q <= cmjd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Helper: cycles from acceptance to the end of a multi-cycle op
  logic [5:0] hc_q;
  always_ff @(posedge mclk) begin
    if (go) begin
      hc_q <= 6'h00;
    end else if (st_q != cmjd_pkg::ST_IDLE) begin
      hc_q <= hc_q + 6'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_take(logic [7:0] op);
    go && instr.opc == op;
  endsequence
  sequence s_addr_phase;
    (xbus_q.ale && xbus_q.ad_oe)[*4] ##1 !xbus_q.ale;
  endsequence

  chk_call_push: assert property (s_take(cmjd_pkg::OP_LONG_SUBROUTINE_CALL) |=>
    sp_q == $past(sp_q) + 8'h02 && pc_q == $past({instr.b2, instr.b3})
    && iram[$past(sp_q) + 8'h01] == $past(ret_addr[7:0]))
    else $error("call push wrong");
  chk_jump_load: assert property (s_take(cmjd_pkg::OP_LONG_BRANCH) |=>
    pc_q == $past({instr.b2, instr.b3}) && carry_q == $past(carry_q))
    else $error("long branch wrong");
  chk_dir_copy: assert property (s_take(cmjd_pkg::OP_DIR_DIR) |=>
    iram[$past(instr.b3)] == $past(iram[instr.b2])
    && pc_q == $past(pc_q) + 16'h0003 && acc_q == $past(acc_q))
    else $error("direct copy wrong");
  chk_bank_reg: assert property (go && instr.opc[7:3] == 5'b11111
    |=> iram[{3'h0, $past(bank), $past(instr.opc[2:0])}] == $past(acc_q))
    else $error("bank register copy wrong");
  chk_bit_carry: assert property (s_take(cmjd_pkg::OP_C_BIT)
    |=> carry_q == $past(bit_val) && acc_q == $past(acc_q))
    else $error("bit copy wrong");
  chk_ptr_load: assert property (s_take(cmjd_pkg::OP_DATA_POINTER16) |=>
    data_pointer16_q[15:8] == $past(instr.b2) && data_pointer16_q[7:0] == $past(instr.b3))
    else $error("pointer load wrong");
  chk_code_addr: assert property (s_take(cmjd_pkg::OP_CODE_PC) |=>
    code_req_q && code_addr_q == $past(pc_q) + 16'h0001
    + {8'h00, $past(acc_q)} && pc_q == $past(pc_q) + 16'h0001)
    else $error("code read address wrong");
  chk_xfer_len: assert property (done_q && $past(st_q)
    == cmjd_pkg::ST_XFER |-> hc_q == 6'd24)
    else $error("external move length wrong");
  chk_short_addr: assert property (go && x_go && !x_dp
    |=> xbus_q.ad == $past(ri_a) and s_addr_phase)
    else $error("short form address wrong");
  chk_long_addr: assert property (go && x_go && x_dp
    |=> p2_q == $past(data_pointer16_q[15:8]) && xbus_q.ad == $past(data_pointer16_q[7:0]))
    else $error("long form address wrong");

endmodule

// ===== pkg/cmjd_pkg.sv
/*
  Shared constants and carrier types for the move, jump and call
  decoder: opcode patterns, reset values, bus timing and structs.
  Assumes a single core clock and a synchronous active-high reset.
*/
package cmjd_pkg;

  // Opcode patterns; ? bits select a bank register or indirect register
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_BRANCH = 8'h02;
  localparam logic [7:0] OP_A_RN = 8'b11101???;
  localparam logic [7:0] OP_A_DIR = 8'he5;
  localparam logic [7:0] OP_A_RI = 8'b1110011?;
  localparam logic [7:0] OP_A_IMM = 8'h74;
  localparam logic [7:0] OP_RN_A = 8'b11111???;
  localparam logic [7:0] OP_RN_DIR = 8'b10101???;
  localparam logic [7:0] OP_RN_IMM = 8'b01111???;
  localparam logic [7:0] OP_DIR_A = 8'hf5;
  localparam logic [7:0] OP_DIR_RN = 8'b10001???;
  localparam logic [7:0] OP_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_DIR_RI = 8'b1000011?;
  localparam logic [7:0] OP_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_RI_A = 8'b1111011?;
  localparam logic [7:0] OP_RI_DIR = 8'b1010011?;
  localparam logic [7:0] OP_RI_IMM = 8'b0111011?;
  localparam logic [7:0] OP_C_BIT = 8'ha2;
  localparam logic [7:0] OP_BIT_C = 8'h92;
  localparam logic [7:0] OP_DATA_POINTER16 = 8'h90;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_XRD_RI = 8'b1110001?;
  localparam logic [7:0] OP_XRD_DP = 8'he0;
  localparam logic [7:0] OP_XWR_RI = 8'b1111001?;
  localparam logic [7:0] OP_XWR_DP = 8'hf0;

  // Program counter steps by instruction length
  localparam logic [15:0] PC0 = 16'h0000;
  localparam logic [15:0] PC1 = 16'h0001;
  localparam logic [15:0] PC2 = 16'h0002;
  localparam logic [15:0] PC3 = 16'h0003;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] DATA_POINTER16_RST = 16'h0000;
  localparam logic [7:0] P2_RST = 8'hff;

  // Internal RAM layout
  localparam logic [7:0] SP_INC = 8'h01;
  localparam logic [2:0] BANK_HI = 3'h0;
  localparam logic [1:0] RI_MID = 2'h0;
  localparam logic [7:0] BIT_RAM = 8'h20;

  // External move timing: two machine cycles of core clocks
  localparam int MC_CLKS = 12;
  localparam int XFER_MCYC = 2;
  localparam int XFER_CLKS = MC_CLKS * XFER_MCYC;
  localparam logic [4:0] XFER_LAST = 5'(XFER_CLKS - 1);
  localparam logic [4:0] ALE_LAST = 5'h03;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CODE = 2'b01,
    ST_XFER = 2'b10
  } cmjd_state_t;

  // One instruction as handed over by the fetch unit
  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b2;
    logic [7:0] b3;
  } cmjd_instr_t;

  // Multiplexed address/data port and its strobes
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic ad_oe;
    logic [7:0] ad;
  } cmjd_xbus_t;

endpackage

// ===== verif/cmjd_xmem.sv
/*
  External data memory model on the multiplexed address/data port.
  Assumes the core's registered strobes and one core clock.
*/
module cmjd_xmem (
  input logic mclk, // Core clock
  input cmjd_pkg::cmjd_xbus_t xbus, // Address/data port, strobes
  input logic [7:0] p2, // High address port
  input logic slow, // Hold read data back for 8 clocks
  output logic [7:0] ad_in // Resolved pin level seen by core
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535]; // Whole 64K data space
  logic [15:0] addr_q; // Latched address
  logic [7:0] wd_q; // Data seen while write strobe low
  logic wr_q = 1'b0; // Write strobe was low last clock
  logic [4:0] rd_cnt_q = 5'h00; // Clocks since read strobe fell
  logic [7:0] last_q = 8'h00; // Last pin level
  logic drive; // Memory drives the pins

  // Address is captured while the latch enable is high
  always @(posedge mclk) begin
    if (xbus.ale) begin
      addr_q <= {p2, ad_in};
    end
  end

  // Write lands on the strobe's rising edge, as a real part would
  always @(posedge mclk) begin
    wr_q <= !xbus.wr_n;
    if (!xbus.wr_n) begin
      wd_q <= ad_in;
    end else if (wr_q) begin
      mem[addr_q] <= wd_q;
    end
  end

  // Read strobe age; slow mode exercises late sampling
  always @(posedge mclk) begin
    rd_cnt_q <= xbus.rd_n ? 5'h00 : rd_cnt_q + 5'h01;
    last_q <= ad_in;
  end

  assign drive = !xbus.rd_n && (!slow || rd_cnt_q >= 5'h08);
  // Floating pins toggle, so a stale value can never pass
  assign ad_in = xbus.ad_oe ? xbus.ad : drive ? mem[addr_q] : ~last_q;
endmodule

// ===== verif/tb.sv
/*
  Self-checking bench for the move, jump and call decoder.
  Assumes cmjd_decode and the external memory model cmjd_xmem.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0; // Core clock, 4 ns
  logic srst = 1'b1; // Reset
  logic instr_valid = 1'b0; // Instruction presented
  cmjd_pkg::cmjd_instr_t instr = '0; // Opcode and operands
  logic [1:0] bank = 2'h1; // Bank one: registers at 08-0f
  logic code_valid = 1'b0; // Code byte answer
  logic [7:0] code_data = 8'h00; // Code byte value
  logic p2_we = 1'b0; // High port latch write
  logic [7:0] p2_wd = 8'h00; // High port latch value
  logic [7:0] ad_in; // Resolved address/data pins
  logic [7:0] dbg_addr = 8'h00; // RAM peek address
  logic slow = 1'b0; // Slow memory answers
  logic done_q, bad_q, carry_q, code_req_q; // Status outputs
  logic [15:0] pc_q, data_pointer16_q, code_addr_q; // Wide outputs
  logic [7:0] acc_q, sp_q, p2_q, dbg_q; // Byte outputs
  cmjd_pkg::cmjd_xbus_t xbus_q; // Port and strobes
  int n_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int lat; // Edges from take to done

  cmjd_decode cmjd_decode_i (.mclk(mclk), .srst(srst),
    .instr_valid(instr_valid), .instr(instr), .bank(bank),
    .code_valid(code_valid), .code_data(code_data), .p2_we(p2_we),
    .p2_wd(p2_wd), .ad_in(ad_in), .dbg_addr(dbg_addr),
    .done_q(done_q), .bad_q(bad_q), .pc_q(pc_q), .acc_q(acc_q),
    .sp_q(sp_q), .data_pointer16_q(data_pointer16_q), .carry_q(carry_q),
    .code_req_q(code_req_q), .code_addr_q(code_addr_q),
    .xbus_q(xbus_q), .p2_q(p2_q), .dbg_q(dbg_q));

  cmjd_xmem cmjd_xmem_i (.mclk(mclk), .xbus(xbus_q), .p2(p2_q),
    .slow(slow), .ad_in(ad_in));

  // Free-running core clock
  initial forever #2 mclk = ~mclk;

  // Program memory content is a function of the address
  function automatic logic [7:0] code_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Program memory answers each request three clocks late
  initial forever begin
    @(posedge mclk);
    if (code_req_q === 1'b1) begin
      repeat (3) @(posedge mclk);
      code_data <= code_byte(code_addr_q);
      code_valid <= 1'b1;
      @(posedge mclk);
      code_valid <= 1'b0;
    end
  end

  task automatic cmp8(input string m, input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cmp16(input string m, input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Present one instruction, wait for done under a bound
  task automatic step(input logic [23:0] ins);
    @(posedge mclk);
    instr <= ins;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    // done_q stands one cycle only, so look before the next edge
    lat = 1;
    #1;
    while (done_q !== 1'b1 && lat < 64) begin
      @(posedge mclk);
      lat++;
      #1;
    end
    cmp8("done", {7'h00, done_q}, 8'h01);
  endtask

  // Internal RAM peek: result registered one clock after address
  task automatic peek(input logic [7:0] a, v);
    @(posedge mclk);
    dbg_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    cmp8("iram", dbg_q, v);
  endtask

  // Run then check: ff means accumulator, fe carry, else RAM
  task automatic step_chk(input logic [23:0] ins, input logic [7:0] a, v);
    step(ins);
    if (a == 8'hff) cmp8("acc", acc_q, v);
    else if (a == 8'hfe) cmp8("carry", {7'h00, carry_q}, v);
    else peek(a, v);
  endtask

  task automatic p2_put(input logic [7:0] v);
    @(posedge mclk);
    p2_wd <= v;
    p2_we <= 1'b1;
    @(posedge mclk);
    p2_we <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    @(posedge mclk);
    #1;
    cmp16("pc", pc_q, 16'h0000);
    cmp8("sp", sp_q, 8'h07);
    cmp16("data_pointer16", data_pointer16_q, 16'h0000);
    cmp8("p2", p2_q, 8'hff);
    $display("test reset finished");
  endtask

  task automatic t_branch;
    step(24'h02ffff);
    cmp16("pc", pc_q, 16'hffff);
    step(24'h020123);
    cmp16("pc", pc_q, 16'h0123);
    cmp8("bad", {7'h00, bad_q}, 8'h00);
    step(24'h121234);
    cmp16("pc", pc_q, 16'h1234);
    cmp8("sp", sp_q, 8'h09);
    peek(8'h08, 8'h26);
    peek(8'h09, 8'h01);
    cmp8("carry", {7'h00, carry_q}, 8'h00);
    // Opcode left to other decoders: flagged, PC holds
    step(24'h000000);
    cmp8("bad", {7'h00, bad_q}, 8'h01);
    cmp16("pc", pc_q, 16'h1234);
    $display("test branch finished");
  endtask

  // All fifteen copy forms, bank one
  task automatic t_bytes;
    step_chk(24'h745500, 8'hff, 8'h55);
    step_chk(24'hfb0000, 8'h0b, 8'h55);
    step_chk(24'h7530a7, 8'h30, 8'ha7);
    step_chk(24'h7e4000, 8'h0e, 8'h40);
    step_chk(24'h783000, 8'h08, 8'h30);
    step_chk(24'h793100, 8'h09, 8'h31);
    step_chk(24'he60000, 8'hff, 8'ha7);
    step_chk(24'hf70000, 8'h31, 8'ha7);
    step_chk(24'he50e00, 8'hff, 8'h40);
    step_chk(24'heb0000, 8'hff, 8'h55);
    step_chk(24'hf53200, 8'h32, 8'h55);
    step_chk(24'h8e3300, 8'h33, 8'h40);
    step_chk(24'h853034, 8'h34, 8'ha7);
    step_chk(24'h873500, 8'h35, 8'ha7);
    step_chk(24'had3200, 8'h0d, 8'h55);
    step_chk(24'ha63300, 8'h30, 8'h40);
    step_chk(24'h77c300, 8'h31, 8'hc3);
    peek(8'h33, 8'h40);
    cmp8("acc", acc_q, 8'h55);
    cmp8("sp", sp_q, 8'h09);
    cmp16("data_pointer16", data_pointer16_q, 16'h0000);
    $display("test bytes finished");
  endtask

  task automatic t_bits;
    step_chk(24'h752001, 8'h20, 8'h01);
    step_chk(24'h752100, 8'h21, 8'h00);
    step_chk(24'h758000, 8'h80, 8'h00);
    step_chk(24'ha20000, 8'hfe, 8'h01);
    step_chk(24'h920f00, 8'h21, 8'h80);
    step_chk(24'h928300, 8'h80, 8'h08);
    step_chk(24'ha20800, 8'hfe, 8'h00);
    peek(8'h20, 8'h01);
    cmp8("acc", acc_q, 8'h55);
    $display("test bits finished");
  endtask

  task automatic t_code;
    step(24'h9012fe);
    cmp16("data_pointer16", data_pointer16_q, 16'h12fe);
    step(24'h740500);
    step(24'h930000);
    cmp16("caddr", code_addr_q, 16'h1303);
    cmp8("acc", acc_q, code_byte(16'h1303));
    cmp16("data_pointer16", data_pointer16_q, 16'h12fe);
    step(24'h74ff00);
    step(24'h0201fe);
    step(24'h830000);
    cmp16("pc", pc_q, 16'h01ff);
    cmp16("caddr", code_addr_q, 16'h02fe);
    cmp8("acc", acc_q, code_byte(16'h02fe));
    $display("test code finished");
  endtask

  // Both external forms, bank two so R0/R1 sit at 10/11
  task automatic t_xmem;
    @(posedge mclk);
    bank <= 2'h2;
    step(24'h901234);
    step(24'h745a00);
    step(24'hf00000);
    cmp8("lat", 8'(lat), 8'h19);
    cmp8("p2", p2_q, 8'h12);
    p2_put(8'h77);
    step_chk(24'h785600, 8'h10, 8'h56);
    step(24'h74c600);
    step(24'hf20000);
    cmp8("lat", 8'(lat), 8'h19);
    cmp8("p2", p2_q, 8'h77);
    p2_put(8'h12);
    step(24'h793400);
    step(24'h740000);
    step_chk(24'he30000, 8'hff, 8'h5a);
    cmp8("lat", 8'(lat), 8'h19);
    slow <= 1'b1;
    step(24'h907756);
    step_chk(24'he00000, 8'hff, 8'hc6);
    slow <= 1'b0;
    $display("test xmem finished");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_branch;
    t_bytes;
    t_bits;
    t_code;
    t_xmem;
    print_verdict;
  end

  // Whole run needs under 300 clocks; the 20000-clock limit means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
